// File: core/dcaa_pkg.sv
package dcaa_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  DCAA_PERIPH_ADDR_OFS = 8'h38;
	localparam logic [7:0]  DCAA_MEM_ADDR_OFS    = 8'h3C;
	localparam logic [7:0]  DCAA_CTRL_OFS        = 8'h30;
	localparam logic [7:0]  DCAA_CUR_PADDR_OFS   = 8'h40;
	localparam logic [7:0]  DCAA_CUR_MADDR_OFS   = 8'h4C;
	localparam logic [31:0] DCAA_ADDR_RST        = 32'h0000_0000;
	localparam logic [31:0] DCAA_CTRL_RST        = 32'h0000_0000;
	// control register field positions
	localparam int DCAA_MWIDTH_LSB = 10;
	localparam int DCAA_PWIDTH_LSB = 8;
	localparam int DCAA_MSTEP_BIT  = 7;
	localparam int DCAA_PSTEP_BIT  = 6;
	localparam logic [31:0] DCAA_CTRL_MASK = 32'h0000_0FC0;
	// width select encodings
	typedef enum logic [1:0] {
		DCAA_W8  = 2'b00,
		DCAA_W16 = 2'b01,
		DCAA_W32 = 2'b10,
		DCAA_WRS = 2'b11
	} dcaa_width_t;
	// address side walk states, gray along idle -> run
	typedef enum logic [1:0] {
		DCAA_IDLE = 2'b00,
		DCAA_RUN  = 2'b01
	} dcaa_state_t;
endpackage

// File: core/dcaa_align.sv
`timescale 1ns/10ps
// forces low address bits to zero for the selected transfer width
module dcaa_align
	import dcaa_pkg::*;
(
	input  wire logic [31:0] base_addr,  // programmed or walking address
	input  wire logic [1:0]  width_sel,  // transfer width select
	output logic      [31:0] align_addr  // aligned address
);
	// ----------------------------------------------------------------
	// alignment
	// ----------------------------------------------------------------
	// reserved code treated like byte width, keeps address untouched
	always_comb begin
		case (dcaa_width_t'(width_sel))
			DCAA_W16: align_addr = {base_addr[31:1], 1'b0};
			DCAA_W32: align_addr = {base_addr[31:2], 2'b00};
			default:  align_addr = base_addr;
		endcase
	end
endmodule // dcaa_align

// File: core/dcaa_channel.sv
// Design decision made here: the APB register port.
`timescale 1ns/10ps
// How it works
// - the peripheral address register supplies the 32-bit base of every peripheral access.
// - with peripheral width 01 bit 0 of the peripheral address is dropped.
// - with peripheral width 10 bits 1 and 0 of the peripheral address are dropped.
// - the memory address register supplies the 32-bit base of every memory access.
// - with memory width 01 bit 0 of the memory address is dropped.
// - with memory width 10 bits 1 and 0 of the memory address are dropped.
// - the memory address register resets to zero and all 32 bits read and write.
// - peripheral width codes are 00 byte, 01 half-word, 10 word, 11 reserved.
// - memory width codes are 00 byte, 01 half-word, 10 word, 11 reserved.
// - with memory step on the memory address advances per transfer, else stays at base.
module dcaa_channel
	import dcaa_pkg::*;
(
	input  wire logic        pclk,          // system clock
	input  wire logic        presetn,       // async reset, active low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [7:0]  paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	input  wire logic [3:0]  pstrb,         // apb byte strobes
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error, unmapped address
	input  wire logic        xfer_start,    // load walking addresses from base
	input  wire logic        xfer_done,     // one transfer finished, step addresses
	output logic      [31:0] periph_addr,   // aligned peripheral bus address
	output logic      [31:0] mem_addr       // aligned memory bus address
);
	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [31:0] periph_base_addr_reg;
	logic [31:0] mem_base_addr_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] periph_cur_reg;
	logic [31:0] mem_cur_reg;
	logic [31:0] periph_cur_next;
	logic [31:0] mem_cur_next;
	logic [31:0] prdata_next;
	logic [31:0] periph_align;
	logic [31:0] mem_align;
	logic [1:0]  periph_width_sel;
	logic [1:0]  mem_width_sel;
	logic        mem_addr_step_on;
	logic        periph_addr_step_on;
	logic        wr_acc;
	logic        hit;
	dcaa_state_t state_reg;
	dcaa_state_t state_next;

	// byte merge under strobes, used by every writable register
	function automatic logic [31:0] dcaa_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// step size in bytes for a width code; reserved steps like a byte
	function automatic logic [31:0] dcaa_step(input logic [1:0] w);
		case (dcaa_width_t'(w))
			DCAA_W16: return 32'h0000_0002;
			DCAA_W32: return 32'h0000_0004;
			default:  return 32'h0000_0001;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// zero wait states: each access completes in its first access cycle
	assign pready = 1'b1;
	assign hit = (paddr == DCAA_PERIPH_ADDR_OFS) || (paddr == DCAA_MEM_ADDR_OFS)
		|| (paddr == DCAA_CTRL_OFS) || (paddr == DCAA_CUR_PADDR_OFS)
		|| (paddr == DCAA_CUR_MADDR_OFS);
	assign pslverr = psel && penable && !hit;
	assign wr_acc = psel && penable && pwrite && hit;

	// control fields, widths decoded per code list
	assign mem_width_sel       = ctrl_reg[DCAA_MWIDTH_LSB +: 2];
	assign periph_width_sel    = ctrl_reg[DCAA_PWIDTH_LSB +: 2];
	assign mem_addr_step_on    = ctrl_reg[DCAA_MSTEP_BIT];
	assign periph_addr_step_on = ctrl_reg[DCAA_PSTEP_BIT];

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// peripheral base, full 32 bits kept even when low bits go unused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_base_addr_reg <= DCAA_ADDR_RST;
		end else if (wr_acc && paddr == DCAA_PERIPH_ADDR_OFS) begin
			periph_base_addr_reg <= dcaa_merge(periph_base_addr_reg, pwdata, pstrb);
		end
	end

	// memory base, cleared at reset, all bits writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_base_addr_reg <= DCAA_ADDR_RST;
		end else if (wr_acc && paddr == DCAA_MEM_ADDR_OFS) begin
			mem_base_addr_reg <= dcaa_merge(mem_base_addr_reg, pwdata, pstrb);
		end
	end

	// control: widths and step enables only, other bits read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= DCAA_CTRL_RST;
		end else if (wr_acc && paddr == DCAA_CTRL_OFS) begin
			ctrl_reg <= dcaa_merge(ctrl_reg, pwdata, pstrb) & DCAA_CTRL_MASK;
		end
	end

	// read mux, registered so data comes from flip-flops
	always_comb begin
		prdata_next = 32'h0000_0000;
		case (paddr)
			DCAA_PERIPH_ADDR_OFS: prdata_next = periph_base_addr_reg;
			DCAA_MEM_ADDR_OFS:    prdata_next = mem_base_addr_reg;
			DCAA_CTRL_OFS:        prdata_next = ctrl_reg;
			DCAA_CUR_PADDR_OFS:   prdata_next = periph_addr;
			DCAA_CUR_MADDR_OFS:   prdata_next = mem_addr;
			default:              prdata_next = 32'h0000_0000;
		endcase
	end

	// read data is captured in setup so it is stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= prdata_next;
		end
	end

	// ----------------------------------------------------------------
	// address walk
	// ----------------------------------------------------------------
	always_comb begin
		state_next      = state_reg;
		periph_cur_next = periph_cur_reg;
		mem_cur_next    = mem_cur_reg;
		case (state_reg)
			DCAA_IDLE: begin
				if (xfer_start) begin
					state_next      = DCAA_RUN;
					periph_cur_next = periph_base_addr_reg;
					mem_cur_next    = mem_base_addr_reg;
				end
			end
			DCAA_RUN: begin
				if (xfer_start) begin
					periph_cur_next = periph_base_addr_reg;
					mem_cur_next    = mem_base_addr_reg;
				end else if (xfer_done) begin
					// step from the aligned value so ignored bits never return
					if (mem_addr_step_on) begin
						mem_cur_next = mem_align + dcaa_step(mem_width_sel);
					end
					if (periph_addr_step_on) begin
						periph_cur_next = periph_align + dcaa_step(periph_width_sel);
					end
				end
			end
			default: state_next = DCAA_IDLE;
		endcase
	end

	// walking address state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= DCAA_IDLE;
			periph_cur_reg <= DCAA_ADDR_RST;
			mem_cur_reg    <= DCAA_ADDR_RST;
		end else begin
			state_reg      <= state_next;
			periph_cur_reg <= periph_cur_next;
			mem_cur_reg    <= mem_cur_next;
		end
	end

	// ----------------------------------------------------------------
	// alignment and outputs
	// ----------------------------------------------------------------
	// byte width passes every bit; 01 and 10 drop low bits
	dcaa_align u_periph_align (
		.base_addr  (periph_cur_reg),
		.width_sel  (periph_width_sel),
		.align_addr (periph_align)
	);

	dcaa_align u_mem_align (
		.base_addr  (mem_cur_reg),
		.width_sel  (mem_width_sel),
		.align_addr (mem_align)
	);

	// address outputs are combinational from flops through the aligners
	assign periph_addr = periph_align;
	assign mem_addr    = mem_align;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_periph_half;
		@(posedge pclk) disable iff (!presetn)
		(periph_width_sel == 2'b01) |-> (periph_addr[0] == 1'b0);
	endproperty
	a_periph_half: assert property (p_periph_half) else $error("periph half not aligned");

	property p_periph_word;
		@(posedge pclk) disable iff (!presetn)
		(periph_width_sel == 2'b10) |-> (periph_addr[1:0] == 2'b00);
	endproperty
	a_periph_word: assert property (p_periph_word) else $error("periph word not aligned");

	property p_mem_half;
		@(posedge pclk) disable iff (!presetn)
		(mem_width_sel == 2'b01) |-> (mem_addr == {mem_cur_reg[31:1], 1'b0});
	endproperty
	a_mem_half: assert property (p_mem_half) else $error("mem half not aligned");

	property p_mem_word;
		@(posedge pclk) disable iff (!presetn)
		(mem_width_sel == 2'b10) |-> (mem_addr == {mem_cur_reg[31:2], 2'b00});
	endproperty
	a_mem_word: assert property (p_mem_word) else $error("mem word not aligned");

	property p_byte_full;
		@(posedge pclk) disable iff (!presetn)
		(mem_width_sel == 2'b00 && periph_width_sel == 2'b00)
			|-> (mem_addr == mem_cur_reg && periph_addr == periph_cur_reg);
	endproperty
	a_byte_full: assert property (p_byte_full) else $error("byte width altered address");

	property p_start_load;
		@(posedge pclk) disable iff (!presetn)
		xfer_start |=> (mem_cur_reg == $past(mem_base_addr_reg)
			&& periph_cur_reg == $past(periph_base_addr_reg));
	endproperty
	a_start_load: assert property (p_start_load) else $error("base not loaded at start");

	property p_mem_fixed;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == DCAA_RUN && xfer_done && !xfer_start && !mem_addr_step_on)
			|=> $stable(mem_cur_reg);
	endproperty
	a_mem_fixed: assert property (p_mem_fixed) else $error("mem address moved");

	property p_mem_step;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == DCAA_RUN && xfer_done && !xfer_start && mem_addr_step_on
			&& mem_width_sel == 2'b10) |=> (mem_cur_reg == $past(mem_align) + 32'h0000_0004);
	endproperty
	a_mem_step: assert property (p_mem_step) else $error("mem word step wrong");

	property p_mem_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == DCAA_MEM_ADDR_OFS && pstrb == 4'hF)
			|=> (mem_base_addr_reg == $past(pwdata));
	endproperty
	a_mem_write: assert property (p_mem_write) else $error("mem base write lost");

	property p_mem_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == DCAA_MEM_ADDR_OFS)
			|=> (prdata == $past(mem_base_addr_reg));
	endproperty
	a_mem_read: assert property (p_mem_read) else $error("mem base readback wrong");

	property p_width_codes;
		@(posedge pclk) disable iff (!presetn)
		(periph_width_sel == 2'b11) |-> (periph_addr == periph_cur_reg);
	endproperty
	a_width_codes: assert property (p_width_codes) else $error("reserved width aligned");

	property p_mem_codes;
		@(posedge pclk) disable iff (!presetn)
		(mem_width_sel == 2'b11) |-> (mem_addr == mem_cur_reg);
	endproperty
	a_mem_codes: assert property (p_mem_codes) else $error("reserved mem width aligned");

	// completions seen before the first start must leave both walking addresses alone
	property p_idle_hold;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == DCAA_IDLE && !xfer_start)
			|=> ($stable(mem_cur_reg) && $stable(periph_cur_reg));
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("address moved before start");

	// half-word peripheral walk stays on even addresses, two bytes per transfer
	property p_periph_step;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == DCAA_RUN && xfer_done && !xfer_start && periph_addr_step_on
			&& periph_width_sel == 2'b01) |=> (periph_cur_reg == $past(periph_align) + 32'h0000_0002);
	endproperty
	a_periph_step: assert property (p_periph_step) else $error("periph half step wrong");
endmodule // dcaa_channel

// File: test/dcaa_bus_tgt.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far side: peripheral register and memory target on the system bus
// ----------------------------------------------------------------
module dcaa_bus_tgt (
	input  wire logic        pclk,         // system clock
	input  wire logic        presetn,      // async reset, active low
	input  wire logic        req,          // bench asks for one transfer
	input  wire logic [3:0]  dly,          // wait cycles before completing
	input  wire logic [31:0] periph_addr,  // address seen on the peripheral side
	input  wire logic [31:0] mem_addr,     // address seen on the memory side
	output logic             xfer_done,    // one-cycle completion pulse
	output logic      [31:0] last_paddr,   // peripheral address used by the transfer
	output logic      [31:0] last_maddr    // memory address used by the transfer
);
	logic [3:0] cnt_reg;
	logic       busy_reg;

	// the bus data phase ends on the done pulse; addresses are taken then,
	// so a design that steps too early shows a wrong captured address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg    <= 4'h0;
			busy_reg   <= 1'b0;
			xfer_done  <= 1'b0;
			last_paddr <= 32'h0000_0000;
			last_maddr <= 32'h0000_0000;
		end else begin
			xfer_done <= 1'b0;
			if (req && !busy_reg) begin
				busy_reg <= 1'b1;
				cnt_reg  <= dly;
			end else if (busy_reg && cnt_reg == 4'h0) begin
				busy_reg   <= 1'b0;
				xfer_done  <= 1'b1;
				last_paddr <= periph_addr;
				last_maddr <= mem_addr;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 4'h1;  // slow answer path
			end
		end
	end
endmodule // dcaa_bus_tgt

// File: test/tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb
	import dcaa_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        xfer_start, xfer_done, req;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, periph_addr, mem_addr, last_paddr, last_maddr, q;
	logic [3:0]  pstrb, dly;
	logic        e;
	int          err_total, n_tests;

	dcaa_channel i_dcaa_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .xfer_start(xfer_start), .xfer_done(xfer_done),
		.periph_addr(periph_addr), .mem_addr(mem_addr));
	dcaa_bus_tgt i_dcaa_bus_tgt (.pclk(pclk), .presetn(presetn), .req(req), .dly(dly),
		.periph_addr(periph_addr), .mem_addr(mem_addr), .xfer_done(xfer_done),
		.last_paddr(last_paddr), .last_maddr(last_maddr));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (err_total == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin err_total++; end_sim(); end
		q = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	function automatic logic [31:0] amask(input logic [1:0] w);
		return (w == DCAA_W16) ? 32'hFFFF_FFFE : (w == DCAA_W32) ? 32'hFFFF_FFFC : 32'hFFFF_FFFF;
	endfunction
	function automatic logic [31:0] astep(input logic [1:0] w);
		return (w == DCAA_W16) ? 32'h2 : (w == DCAA_W32) ? 32'h4 : 32'h1;
	endfunction
	task automatic start();
		@(posedge pclk) xfer_start <= 1'b1;
		@(posedge pclk) xfer_start <= 1'b0;
		#1;
	endtask
	// ask the far side for one transfer, wait bounded for its completion
	task automatic xfer(input logic [3:0] d);
		int i;
		@(posedge pclk) begin req <= 1'b1; dly <= d; end
		@(posedge pclk) req <= 1'b0;
		for (i = 0; i < 24; i++) begin
			@(posedge pclk);
			if (xfer_done === 1'b1) break;
		end
		if (i == 24) begin err_total++; end_sim(); end
		#1;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		apb(1'b0, DCAA_MEM_ADDR_OFS, 32'h0); `CHK(q, DCAA_ADDR_RST)
		apb(1'b0, DCAA_PERIPH_ADDR_OFS, 32'h0); `CHK(q, 32'h0000_0000)
		// completion before any start must not move the address
		xfer(4'h0); `CHK(mem_addr, 32'h0000_0000)
	endtask
	task automatic t_regs();
		apb(1'b1, DCAA_MEM_ADDR_OFS, 32'hFFFF_FFFF);
		apb(1'b0, DCAA_MEM_ADDR_OFS, 32'h0); `CHK(q, 32'hFFFF_FFFF)
		apb(1'b1, DCAA_MEM_ADDR_OFS, 32'h5A5A_A5A5);
		apb(1'b0, DCAA_MEM_ADDR_OFS, 32'h0); `CHK(q, 32'h5A5A_A5A5)
		// lower half only: the upper bytes keep the earlier value
		pstrb <= 4'h3;
		apb(1'b1, DCAA_MEM_ADDR_OFS, 32'h1234_5678);
		pstrb <= 4'hF;
		apb(1'b0, DCAA_MEM_ADDR_OFS, 32'h0); `CHK(q, 32'h5A5A_5678)
		apb(1'b1, DCAA_PERIPH_ADDR_OFS, 32'hA5A5_5A5B);
		apb(1'b0, DCAA_PERIPH_ADDR_OFS, 32'h0); `CHK(q, 32'hA5A5_5A5B)
		apb(1'b1, DCAA_CTRL_OFS, 32'hFFFF_FFFF);
		apb(1'b0, DCAA_CTRL_OFS, 32'h0); `CHK(q, DCAA_CTRL_MASK)
		// unmapped place: refused with error, reads zero
		apb(1'b0, 8'h10, 32'h0); `CHK({e, q}, {1'b1, 32'h0000_0000})
	endtask
	// every width code on both sides, then memory-side stepping per transfer
	task automatic t_widths();
		logic [31:0] pb, mb;
		pb = 32'h1234_5677;
		mb = 32'h89AB_CDEF;
		for (int w = 0; w < 4; w++) begin
			apb(1'b1, DCAA_PERIPH_ADDR_OFS, pb);
			apb(1'b1, DCAA_MEM_ADDR_OFS, mb);
			apb(1'b1, DCAA_CTRL_OFS, (32'(w) << DCAA_MWIDTH_LSB) | (32'(w) << DCAA_PWIDTH_LSB)
				| (32'h1 << DCAA_MSTEP_BIT));
			start();
			`CHK(periph_addr, pb & amask(w[1:0]))
			`CHK(mem_addr, mb & amask(w[1:0]))
			xfer(w[3:0]);
			`CHK(last_maddr, mb & amask(w[1:0]))
			`CHK(last_paddr, pb & amask(w[1:0]))
			`CHK(mem_addr, (mb & amask(w[1:0])) + astep(w[1:0]))
			xfer(4'h0);
			`CHK(mem_addr, (mb & amask(w[1:0])) + 32'h2 * astep(w[1:0]))
		end
	endtask
	// step off: the memory address stays at its base over transfers,
	// while the peripheral side walks in half-words from its aligned base
	task automatic t_step_off();
		apb(1'b1, DCAA_MEM_ADDR_OFS, 32'h2000_0006);
		apb(1'b1, DCAA_PERIPH_ADDR_OFS, 32'h4000_0003);
		apb(1'b1, DCAA_CTRL_OFS, (32'(DCAA_W32) << DCAA_MWIDTH_LSB)
			| (32'(DCAA_W16) << DCAA_PWIDTH_LSB) | (32'h1 << DCAA_PSTEP_BIT));
		start();
		`CHK(periph_addr, 32'h4000_0002)
		xfer(4'h2);
		xfer(4'h0);
		`CHK(mem_addr, 32'h2000_0004)
		`CHK(last_paddr, 32'h4000_0004)
		`CHK(periph_addr, 32'h4000_0006)
		apb(1'b0, DCAA_CUR_MADDR_OFS, 32'h0); `CHK(q, 32'h2000_0004)
		apb(1'b0, DCAA_CUR_PADDR_OFS, 32'h0); `CHK(q, 32'h4000_0006)
	endtask

	// ----------------------------------------------------------------
	// clock, reset and main sequence
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		err_total = 0; n_tests = 0;
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; pstrb = 4'hF; xfer_start = 1'b0; req = 1'b0; dly = 4'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_widths();
		t_step_off();
		end_sim();
	end
endmodule // tb
